// ==== rttb_defs.vh ====
`ifndef RTTB_DEFS_VH
`define RTTB_DEFS_VH
// Function
// [RULE_01] 16-bit host read-write configuration word
// [RULE_02] master reset clears; software reset keeps
// [RULE_03] bits 15:14 pick rt-rt no-response timeout
// [RULE_04] 11=150us 10=125us 01=100us 00=57us
// [RULE_05] bit 13 stages receive words, 32 deep
// [RULE_06] staged words burst out on clean completion; code bursts none when 32 words are staged (wcnt_reg wraps to 0)
// [RULE_07] unstaged words written straight on arrival
// [RULE_08] host changes bit 13 only when idle
// [RULE_09] host may read and write staging buffer
// [RULE_10] bit 12 rising loads time-tag counter
// [RULE_11] load strobe clears itself after load
// [RULE_12] only a 0 to 1 write triggers load
`define RTTB_OFF_CFG       4'h1
`define RTTB_OFF_STAT      4'h2
`define RTTB_OFF_ENA       4'h3
`define RTTB_OFF_CLR       4'h0
`define RTTB_OFF_BUF       6'h20
`define RTTB_CFG_RESET     16'h0000
`define RTTB_BIT_TOSEL_HI  15
`define RTTB_BIT_TOSEL_LO  14
`define RTTB_BIT_STAGE     13
`define RTTB_BIT_TIMETAG_LOAD_STROBE    12
`define RTTB_TO_150_NS     150000
`define RTTB_TO_125_NS     125000
`define RTTB_TO_100_NS     100000
`define RTTB_TO_57_NS      57000
`define RTTB_CLK_NS        4
`define RTTB_EV_TIMEOUT    0
`define RTTB_EV_COMMIT     1
`define RTTB_EV_TIMETAG_LOAD_STROBE     2
`endif

// ==== rttb_stage_ram.v ====
`timescale 1ns/100ps
`include "rttb_defs.vh"
module rttb_stage_ram
(
  input  wire        clk,
  input  wire        we_a,
  input  wire [4:0]  addr_a,
  input  wire [15:0] wdata_a,
  output reg  [15:0] rdata_a,
  input  wire        we_b,
  input  wire [4:0]  addr_b,
  input  wire [15:0] wdata_b
);
  reg [15:0] mem [0:31];
  always @(posedge clk)
  begin
    if (we_a)
      mem[addr_a] <= wdata_a;
    else if (we_b)
      mem[addr_b] <= wdata_b;
    rdata_a <= mem[addr_a];
  end
endmodule // rttb_stage_ram

// ==== rttb_config.v ====
`timescale 1ns/100ps
`include "rttb_defs.vh"
module rttb_config
(
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        SOFT_RESET,
  input  wire [5:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  input  wire        EXEC_ENABLE,
  input  wire        CMD_RT_RT_RX,
  input  wire        TX_STARTED,
  input  wire        RX_WORD_VALID,
  input  wire [15:0] RX_WORD,
  input  wire        MSG_DONE,
  input  wire        MSG_ERROR,
  input  wire [15:0] TIMETAG_UTIL,
  output reg         TIMETAG_LOAD,
  output reg  [15:0] TIMETAG_VALUE,
  output reg         TIMEOUT_ERROR,
  output reg         MEM_WE,
  output reg  [4:0]  MEM_ADDR,
  output reg  [15:0] MEM_WDATA,
  output reg         IRQ
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_RECV  = 2'h1;
  localparam ST_BURST = 2'h2;
  localparam [17:0] CNT_150 = `RTTB_TO_150_NS / `RTTB_CLK_NS;
  localparam [17:0] CNT_125 = `RTTB_TO_125_NS / `RTTB_CLK_NS;
  localparam [17:0] CNT_100 = `RTTB_TO_100_NS / `RTTB_CLK_NS;
  localparam [17:0] CNT_57  = `RTTB_TO_57_NS / `RTTB_CLK_NS;
  reg  [15:0] cfg_reg;
  reg  [2:0]  stat_reg;
  reg  [2:0]  ena_reg;
  reg  [1:0]  state_reg;
  reg  [4:0]  wcnt_reg;
  reg  [4:0]  bcnt_reg;
  reg  [17:0] to_cnt_reg;
  reg         to_run_reg;
  reg         rd_pend_reg;
  reg         rd_buf_reg;
  reg  [17:0] to_limit;
  reg  [2:0]  ev;
  reg  [15:0] cfg_next;
  wire        acc;
  wire        buf_sel;
  wire        host_buf_we;
  wire [15:0] buf_rdata;
  wire        stage_we;
  wire        wr_cfg;
  wire        ttl_rise;
  wire        burst_rd;
  wire [4:0]  ram_addr_a;
  assign acc = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
  assign buf_sel = AVS_ADDRESS[5];
  assign wr_cfg = acc & AVS_WRITE & ~buf_sel &
                  (AVS_ADDRESS[3:0] == `RTTB_OFF_CFG);
  assign host_buf_we = acc & AVS_WRITE & buf_sel; // [RULE_09]
  assign stage_we = cfg_reg[`RTTB_BIT_STAGE] & RX_WORD_VALID &
                    ((state_reg == ST_RECV) |
                     ((state_reg == ST_IDLE) & EXEC_ENABLE)); // [RULE_05]
  assign burst_rd = (state_reg == ST_BURST);
  assign ram_addr_a = burst_rd ? bcnt_reg : AVS_ADDRESS[4:0];
  assign ttl_rise = wr_cfg & AVS_WRITEDATA[`RTTB_BIT_TIMETAG_LOAD_STROBE] &
                    ~cfg_reg[`RTTB_BIT_TIMETAG_LOAD_STROBE]; // [RULE_12]
  rttb_stage_ram u_ram
  (
    .clk     (CLK),
    .we_a    (host_buf_we & ~burst_rd),
    .addr_a  (ram_addr_a),
    .wdata_a (AVS_WRITEDATA[15:0]),
    .rdata_a (buf_rdata),
    .we_b    (stage_we),
    .addr_b  (wcnt_reg),
    .wdata_b (RX_WORD)
  );
  ////////////////////////////////////////////////////////////////////////
  // timeout select
  always @*
  begin
    case (cfg_reg[`RTTB_BIT_TOSEL_HI:`RTTB_BIT_TOSEL_LO]) // [RULE_04]
      2'h3: to_limit = CNT_150;
      2'h2: to_limit = CNT_125;
      2'h1: to_limit = CNT_100;
      default: to_limit = CNT_57;
    endcase
  end
  always @*
  begin
    cfg_next = cfg_reg;
    if (wr_cfg)
      cfg_next = AVS_WRITEDATA[15:0]; // [RULE_01]
    if (ttl_rise | ~wr_cfg)
      cfg_next[`RTTB_BIT_TIMETAG_LOAD_STROBE] = 1'b0; // [RULE_11]
  end
  ////////////////////////////////////////////////////////////////////////
  // configuration word, not touched by soft reset
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cfg_reg <= `RTTB_CFG_RESET; // [RULE_02]
      TIMETAG_LOAD <= 1'b0;
      TIMETAG_VALUE <= 16'h0000;
    end
    else
    begin
      cfg_reg <= cfg_next;
      TIMETAG_LOAD <= ttl_rise; // [RULE_10]
      if (ttl_rise)
        TIMETAG_VALUE <= TIMETAG_UTIL; // [RULE_10]
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // rt-rt timeout and receive path
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      to_cnt_reg <= 18'h00000;
      to_run_reg <= 1'b0;
      TIMEOUT_ERROR <= 1'b0;
      state_reg <= ST_IDLE;
      wcnt_reg <= 5'h00;
      bcnt_reg <= 5'h00;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 5'h00;
      MEM_WDATA <= 16'h0000;
    end
    else
    begin
      TIMEOUT_ERROR <= 1'b0;
      MEM_WE <= 1'b0;
      if (SOFT_RESET)
      begin
        to_run_reg <= 1'b0;
        state_reg <= ST_IDLE;
      end
      else
      begin
        if (CMD_RT_RT_RX & EXEC_ENABLE)
        begin
          to_run_reg <= 1'b1;
          to_cnt_reg <= 18'h00000;
        end
        else if (to_run_reg)
        begin
          if (TX_STARTED)
            to_run_reg <= 1'b0;
          else if (to_cnt_reg >= to_limit - 18'h00001)
          begin
            to_run_reg <= 1'b0;
            TIMEOUT_ERROR <= 1'b1; // [RULE_03]
          end
          else
            to_cnt_reg <= to_cnt_reg + 18'h00001;
        end
        case (state_reg)
          ST_IDLE:
          begin
            wcnt_reg <= 5'h00;
            if (EXEC_ENABLE & RX_WORD_VALID)
              state_reg <= ST_RECV;
          end
          default: state_reg <= ST_IDLE;
        endcase
        if (state_reg == ST_IDLE & EXEC_ENABLE & RX_WORD_VALID &
            ~cfg_reg[`RTTB_BIT_STAGE])
        begin
          MEM_WE <= 1'b1; // [RULE_07]
          MEM_ADDR <= 5'h00;
          MEM_WDATA <= RX_WORD;
          wcnt_reg <= 5'h01;
        end
        if (state_reg == ST_IDLE & EXEC_ENABLE & RX_WORD_VALID &
            cfg_reg[`RTTB_BIT_STAGE])
          wcnt_reg <= 5'h01; // [RULE_05]
        if (state_reg == ST_RECV)
        begin
          state_reg <= ST_RECV;
          if (RX_WORD_VALID)
          begin
            wcnt_reg <= wcnt_reg + 5'h01;
            if (~cfg_reg[`RTTB_BIT_STAGE])
            begin
              MEM_WE <= 1'b1; // [RULE_07]
              MEM_ADDR <= wcnt_reg;
              MEM_WDATA <= RX_WORD;
            end
          end
          if (MSG_DONE)
          begin
            bcnt_reg <= 5'h00;
            if (cfg_reg[`RTTB_BIT_STAGE] & ~MSG_ERROR)
              state_reg <= ST_BURST; // [RULE_06]
            else
              state_reg <= ST_IDLE;
          end
        end
        if (state_reg == ST_BURST)
        begin
          state_reg <= ST_BURST;
          bcnt_reg <= bcnt_reg + 5'h01;
          if (bcnt_reg != 5'h00)
          begin
            MEM_WE <= 1'b1; // [RULE_06]
            MEM_ADDR <= bcnt_reg - 5'h01;
            MEM_WDATA <= buf_rdata;
          end
          if (bcnt_reg == wcnt_reg)
            state_reg <= ST_IDLE;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // bus slave and interrupts
  always @*
  begin
    ev = 3'h0;
    ev[`RTTB_EV_TIMEOUT] = TIMEOUT_ERROR;
    ev[`RTTB_EV_COMMIT] = burst_rd & (bcnt_reg == wcnt_reg);
    ev[`RTTB_EV_TIMETAG_LOAD_STROBE] = TIMETAG_LOAD;
  end
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      stat_reg <= 3'h0;
      ena_reg <= 3'h0;
      IRQ <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      rd_pend_reg <= 1'b0;
      rd_buf_reg <= 1'b0;
    end
    else
    begin
      if (acc & AVS_WRITE & ~buf_sel &
          AVS_ADDRESS[3:0] == `RTTB_OFF_CLR)
        stat_reg <= (stat_reg & ~AVS_WRITEDATA[2:0]) | ev;
      else
        stat_reg <= stat_reg | ev;
      if (acc & AVS_WRITE & ~buf_sel &
          AVS_ADDRESS[3:0] == `RTTB_OFF_ENA)
        ena_reg <= AVS_WRITEDATA[2:0];
      IRQ <= |(stat_reg & ena_reg);
      AVS_WAITREQUEST <= 1'b1;
      rd_pend_reg <= 1'b0;
      if (AVS_WAITREQUEST & AVS_WRITE & ~(buf_sel & burst_rd))
        AVS_WAITREQUEST <= 1'b0;
      if (AVS_WAITREQUEST & AVS_READ & ~rd_pend_reg & ~burst_rd)
      begin
        rd_pend_reg <= 1'b1;
        rd_buf_reg <= buf_sel;
      end
      if (rd_pend_reg & AVS_WAITREQUEST & AVS_READ)
      begin
        AVS_WAITREQUEST <= 1'b0;
        if (rd_buf_reg)
          AVS_READDATA <= {16'h0000, buf_rdata}; // [RULE_09]
        else if (AVS_ADDRESS[3:0] == `RTTB_OFF_CFG)
          AVS_READDATA <= {16'h0000, cfg_reg}; // [RULE_01]
        else if (AVS_ADDRESS[3:0] == `RTTB_OFF_STAT)
          AVS_READDATA <= {29'h00000000, stat_reg};
        else if (AVS_ADDRESS[3:0] == `RTTB_OFF_ENA)
          AVS_READDATA <= {29'h00000000, ena_reg};
        else
          AVS_READDATA <= 32'h00000000;
      end
    end
  end
endmodule // rttb_config

// ==== rttb_properties.sv ====
`timescale 1ns/100ps
module rttb_props
(
  input logic        CLK,
  input logic        RESET_N,
  input logic [5:0]  AVS_ADDRESS,
  input logic        AVS_READ,
  input logic        AVS_WRITE,
  input logic [31:0] AVS_READDATA,
  input logic        AVS_WAITREQUEST,
  input logic        CMD_RT_RT_RX,
  input logic        TIMETAG_LOAD,
  input logic        TIMEOUT_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wr_ack_a: assert property (AVS_WRITE && AVS_WAITREQUEST
    && !AVS_ADDRESS[5] |=> !AVS_WAITREQUEST) else $error("no write ack");
  rd_ack_a: assert property (AVS_READ && AVS_WAITREQUEST
    && !AVS_ADDRESS[5] |-> ##[1:2] !AVS_WAITREQUEST) else $error("no read ack");
  ack_one_a: assert property (!AVS_WAITREQUEST
    |=> AVS_WAITREQUEST) else $error("ack too long");
  rd_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST
    |-> AVS_READDATA[31:16] == 16'h0000) else $error("upper set");
  rd_hole_a: assert property (AVS_READ && !AVS_WAITREQUEST
    && AVS_ADDRESS[5:2] == 4'h1 |-> AVS_READDATA == 32'h0) else $error("hole");
  load_one_a: assert property (TIMETAG_LOAD |=> !TIMETAG_LOAD)
    else $error("load too long");
  load_cause_a: assert property (TIMETAG_LOAD |-> $past(AVS_WRITE)
    || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("stray load");
  to_early_a: assert property (CMD_RT_RT_RX |=> !TIMEOUT_ERROR [*8])
    else $error("early timeout");
endmodule // rttb_props
bind rttb_config rttb_props u_props (.CLK(CLK), .RESET_N(RESET_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CMD_RT_RT_RX(CMD_RT_RT_RX), .TIMETAG_LOAD(TIMETAG_LOAD),
  .TIMEOUT_ERROR(TIMEOUT_ERROR));

// ==== rttb_host.sv ====
`timescale 1ns/100ps
module rttb_host
(
  input  wire        CLK,
  output reg  [5:0]  AVS_ADDRESS,
  output reg         AVS_READ,
  output reg         AVS_WRITE,
  output reg  [31:0] AVS_WRITEDATA,
  input  wire [31:0] AVS_READDATA,
  input  wire        AVS_WAITREQUEST
);
  initial
  begin
    AVS_ADDRESS = 6'h00;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0;
  end
  // one cycle, held to ack; staging bit only set with exec low
  task xfer(input logic r, input logic [5:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= r;
    AVS_WRITE <= !r;
    AVS_WRITEDATA <= {16'h0000, d};
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA[15:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    AVS_WRITEDATA <= ~AVS_WRITEDATA;
  endtask
endmodule // rttb_host

// ==== rttb_tb.sv ====
`timescale 1ns/100ps
`include "rttb_defs.vh"
module testbench;
  logic        clk, rst_n, srst, rd, wr, wt, ex, cmd, txs, rxv, dn, er;
  logic        ttl, toe, mwe, irq;
  logic [5:0]  ad;
  logic [31:0] wd, rdt;
  logic [15:0] rxw, ut, ttv, mwd, q;
  logic [4:0]  mad;
  logic [15:0] mem [0:31];
  int          n_errors, total_checks, n_we, n_ld, cyc, n;
  rttb_host host (.CLK(clk), .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdt), .AVS_WAITREQUEST(wt));
  rttb_config DUT (.CLK(clk), .RESET_N(rst_n), .SOFT_RESET(srst),
    .AVS_ADDRESS(ad), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdt), .AVS_WAITREQUEST(wt), .EXEC_ENABLE(ex),
    .CMD_RT_RT_RX(cmd), .TX_STARTED(txs), .RX_WORD_VALID(rxv), .RX_WORD(rxw),
    .MSG_DONE(dn), .MSG_ERROR(er), .TIMETAG_UTIL(ut), .TIMETAG_LOAD(ttl),
    .TIMETAG_VALUE(ttv), .TIMEOUT_ERROR(toe), .MEM_WE(mwe), .MEM_ADDR(mad),
    .MEM_WDATA(mwd), .IRQ(irq));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (mwe === 1'b1) mem[mad] <= mwd;
    if (mwe === 1'b1) n_we <= n_we + 1;
    if (ttl === 1'b1) n_ld <= n_ld + 1;
    if (cyc == 99000)
    begin
      n_errors++;
      end_sim;
    end
  end
  task check(input logic [31:0] s, input logic [31:0] e, input string w);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s exp %h seen %h", w, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wrr(input logic [5:0] a, input logic [15:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task pulse_cmd;
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
  endtask
  task wait_to(input int m);
    n = 0;
    while (toe !== 1'b1 && n < m)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task send(input int k, input logic [15:0] b, input logic e);
    for (int i = 0; i < k; i++)
    begin
      @(posedge clk);
      rxv <= 1'b1;
      rxw <= b + 16'(i);
    end
    @(posedge clk);
    rxv <= 1'b0;
    dn <= 1'b1;
    er <= e;
    @(posedge clk);
    dn <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  //////////////////////////////////
  task t_regs;
    host.xfer(1'b1, 6'h01, 16'h0, q);
    check(q, 16'h0000, "cfg reset");
    wrr(6'h01, 16'ha000);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    host.xfer(1'b1, 6'h01, 16'h0, q);
    check(q, 16'ha000, "cfg soft");
    host.xfer(1'b1, 6'h07, 16'h0, q);
    check(q, 16'h0000, "hole");
    $display("regs done");
  endtask
  task t_ttag;
    ut <= 16'ha5c3;
    wrr(6'h03, 16'h0004);
    wrr(6'h01, 16'h5000);
    repeat (4) @(posedge clk);
    check(n_ld, 1, "load");
    check(ttv, 16'ha5c3, "tag");
    check(irq, 1'b1, "irq");
    host.xfer(1'b1, 6'h01, 16'h0, q);
    check(q, 16'h4000, "strobe");
    wrr(6'h03, 16'h0000);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "mask");
    wrr(6'h03, 16'h0004);
    wrr(6'h00, 16'h0004);
    repeat (2) @(posedge clk);
    check(irq, 1'b0, "clear");
    wrr(6'h01, 16'hc000);
    repeat (4) @(posedge clk);
    check(n_ld, 1, "no load");
    $display("ttag done");
  endtask
  task t_stage;
    wrr(6'h01, 16'h0000);
    ex <= 1'b1;
    send(3, 16'h1110, 1'b1);
    check(n_we, 3, "direct");
    check(mem[2], 16'h1112, "direct word");
    ex <= 1'b0;
    wrr(6'h01, 16'h2000);
    ex <= 1'b1;
    send(3, 16'h2220, 1'b1);
    check(n_we, 3, "held");
    send(4, 16'h3330, 1'b0);
    check(n_we, 7, "burst");
    check(mem[3], 16'h3333, "burst word");
    wrr(6'h25, 16'hbeef);
    host.xfer(1'b1, 6'h25, 16'h0, q);
    check(q, 16'hbeef, "buffer");
    host.xfer(1'b1, 6'h02, 16'h0, q);
    check(q, 16'h0002, "commit status");
    $display("stage done");
  endtask
  task t_tmo;
    int lim [4] = '{`RTTB_TO_57_NS / `RTTB_CLK_NS,
      `RTTB_TO_100_NS / `RTTB_CLK_NS, `RTTB_TO_125_NS / `RTTB_CLK_NS,
      `RTTB_TO_150_NS / `RTTB_CLK_NS};
    ex <= 1'b1;
    for (int s = 0; s < 4; s += 1 + (s == 1))
    begin
      wrr(6'h01, 16'(s << 14));
      pulse_cmd;
      wait_to(40000);
      check(n >= lim[s] - 1 && n <= lim[s] + 2, 1'b1, "timeout");
    end
    wrr(6'h01, 16'h0000);
    pulse_cmd;
    txs <= 1'b1;
    @(posedge clk);
    txs <= 1'b0;
    wait_to(lim[0] + 100);
    check(n, lim[0] + 100, "started");
    $display("timeout done");
  endtask
  initial
  begin
    {rst_n, srst, ex, cmd, txs, rxv, dn, er} = 8'h00;
    rxw = 16'h0;
    ut = 16'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_ttag;
    t_stage;
    t_tmo;
    end_sim;
  end
endmodule // testbench
